//--- shared/triple_timer_counter_unit_map.vh
// register map, field positions and constants of the triple timer/counter unit
`ifndef TRIPLE_TIMER_COUNTER_UNIT_MAP_VH
`define TRIPLE_TIMER_COUNTER_UNIT_MAP_VH
`define IDX_TIMER_CONTROL      8'h88
`define IDX_TIMER_MODE_SELECT  8'h89
`define IDX_TIMER0_COUNT_LOW   8'h8A
`define IDX_TIMER1_COUNT_LOW   8'h8B
`define IDX_TIMER0_COUNT_HIGH  8'h8C
`define IDX_TIMER1_COUNT_HIGH  8'h8D
`define IDX_CLOCK_MODE         8'h8E
`define IDX_TIMER2_CONTROL     8'hC8
`define IDX_TIMER2_MODE_SELECT 8'hC9
`define IDX_TIMER2_RELOAD_LOW  8'hCA
`define IDX_TIMER2_RELOAD_HIGH 8'hCB
`define IDX_TIMER2_COUNT_LOW   8'hCC
`define IDX_TIMER2_COUNT_HIGH  8'hCD
`define RST_BYTE               8'h00
`define TC_TF1 7
`define TC_TR1 6
`define TC_TF0 5
`define TC_TR0 4
`define TC_IE1 3
`define TC_IT1 2
`define TC_IE0 1
`define TC_IT0 0
`define TM_GATE 3
`define TM_CT   2
`define T2C_TF2   7
`define T2C_TIMER2_EXTERNAL_FLAG  6
`define T2C_RCLK  5
`define T2C_SERIAL_TX_CLOCK_SELECT  4
`define T2C_TIMER2_EXTERNAL_ENABLE 3
`define T2C_TR2   2
`define T2C_CT2   1
`define T2C_CPRL2 0
`define T2M_OE    1
`define T2M_TIMER2_UPDOWN_ENABLE  0
`define T2M_MASK  8'h03
`define MODE_13BIT  2'h0
`define MODE_16BIT  2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT  2'h3
`define MC_DIV_STD  12
`define MC_DIV_FAST 6
`define PIN_EXT_IRQ0_PIN 0
`define PIN_EXT_IRQ1_PIN 1
`define PIN_T0   2
`define PIN_T1   3
`define PIN_T2   4
`define PIN_TIMER2_TRIGGER_PIN 5
`endif

//--- src/triple_timer_counter_unit.v
// three timer/counters with avalon-mm register access
`timescale 1ns/100ps
`default_nettype none
`include "triple_timer_counter_unit_map.vh"
module triple_timer_counter_unit #(
  parameter MC_DIV_STD  = `MC_DIV_STD,
  parameter MC_DIV_FAST = `MC_DIV_FAST
) (
  input  wire        ref_clk_in,
  input  wire        srst_in,
  input  wire [9:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        ext_irq0_pin_in,
  input  wire        ext_irq1_pin_in,
  input  wire        timer0_count_pin_in,
  input  wire        timer1_count_pin_in,
  input  wire        timer2_count_pin_in,
  input  wire        timer2_trigger_pin_in,
  input  wire        ext_irq0_ack_in,
  input  wire        ext_irq1_ack_in,
  input  wire        timer0_ack_in,
  input  wire        timer1_ack_in,
  output reg         ext_irq0_req_out,
  output reg         ext_irq1_req_out,
  output reg         timer0_irq_out,
  output reg         timer1_irq_out,
  output reg         timer2_irq_out,
  output reg         serial_rx_tick_out,
  output reg         serial_tx_tick_out,
  output reg         clockout_port_pin_out,
  output reg         clockout_port_pin_oe_n_out
);

  reg  [7:0]  timer_control_r;
  reg  [7:0]  timer_mode_select_r;
  reg  [7:0]  tl0_r;
  reg  [7:0]  th0_r;
  reg  [7:0]  tl1_r;
  reg  [7:0]  th1_r;
  reg         fast_r;
  reg  [7:0]  timer2_control_r;
  reg  [7:0]  timer2_mode_select_r;
  reg  [7:0]  rcapl_r;
  reg  [7:0]  rcaph_r;
  reg  [7:0]  tl2_r;
  reg  [7:0]  th2_r;
  reg  [3:0]  mc_cnt_r;
  reg  [5:0]  pin_cur_r;
  reg  [5:0]  pin_prev_r;
  reg  [7:0]  timer_control_nxt;
  reg  [7:0]  tl0_nxt;
  reg  [7:0]  th0_nxt;
  reg  [7:0]  tl1_nxt;
  reg  [7:0]  th1_nxt;
  reg  [7:0]  timer2_control_nxt;
  reg  [15:0] t2_nxt;
  reg  [15:0] rcap_nxt;
  reg         t1_ovf;
  reg         t2_ovf;
  reg  [7:0]  rd_byte;
  reg  [16:0] s0;
  reg  [16:0] s1;
  reg  [8:0]  h0;
  wire        req;
  wire        acc;
  wire        wr;
  wire [7:0]  idx;
  wire [7:0]  wd;
  wire        mc_tick;
  wire [3:0]  mc_lim;
  wire [5:0]  pins;
  wire [5:0]  fall;
  wire [1:0]  mode0;
  wire [1:0]  mode1;
  wire        split0;
  wire        en0;
  wire        en1;
  wire        inc0;
  wire        inc1;
  wire        inc0h;
  wire        baud;
  wire        timer2_updown_enable;
  wire        timer2_clockout_enable;
  wire        inc2;
  wire        exev;
  wire        updown;
  wire        capmode;
  wire [15:0] t2;
  wire [15:0] rcap;

  // avalon slave: one wait state, request taken when waitrequest is low
  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~avs_waitrequest_out;
  assign idx = avs_address_in[9:2];
  assign wd  = avs_writedata_in[7:0];
  assign wr  = avs_write_in & acc & avs_byteenable_in[0];

  // machine cycle divider, 12 or 6 clocks
  assign mc_lim  = fast_r ? MC_DIV_FAST[3:0] - 4'h1 : MC_DIV_STD[3:0] - 4'h1;
  // at or past the limit, so a switch to the short cycle never waits for a wrap
  assign mc_tick = (mc_cnt_r >= mc_lim);

  // pin sampling once per machine cycle
  assign pins = {timer2_trigger_pin_in, timer2_count_pin_in, timer1_count_pin_in,
                 timer0_count_pin_in, ext_irq1_pin_in, ext_irq0_pin_in};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pin
      always @(posedge ref_clk_in) begin
        if (srst_in) begin
          pin_cur_r[gi]  <= 1'b1;
          pin_prev_r[gi] <= 1'b1;
        end else if (mc_tick) begin
          pin_cur_r[gi]  <= pins[gi];
          pin_prev_r[gi] <= pin_cur_r[gi];
        end
      end
      assign fall[gi] = mc_tick & pin_prev_r[gi] & ~pin_cur_r[gi];
    end
  endgenerate

  // one step of timer 0 or 1: {overflow, high, low}
  function [16:0] t01_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg   [12:0] c13;
    reg   [16:0] c16;
    reg   [8:0]  c8;
    begin
      c13 = {hi, lo[4:0]} + 13'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8  = {1'b0, lo} + 9'h001;
      case (mode)
        `MODE_13BIT:  t01_step = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], 3'h0, c13[4:0]};
        `MODE_16BIT:  t01_step = c16;
        `MODE_RELOAD: t01_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
        default:      t01_step = {c8[8], hi, c8[7:0]};
      endcase
    end
  endfunction

  // timer 0 and timer 1 gating
  assign mode0  = timer_mode_select_r[1:0];
  assign mode1  = timer_mode_select_r[5:4];
  assign split0 = (mode0 == `MODE_SPLIT);
  assign en0 = timer_control_r[`TC_TR0] & (~timer_mode_select_r[`TM_GATE] | pin_cur_r[`PIN_EXT_IRQ0_PIN]);
  assign en1 = timer_control_r[`TC_TR1] & (~timer_mode_select_r[`TM_GATE + 4] | pin_cur_r[`PIN_EXT_IRQ1_PIN]);
  assign inc0 = en0 & (timer_mode_select_r[`TM_CT] ? fall[`PIN_T0] : mc_tick);
  assign inc1 = en1 & (timer_mode_select_r[`TM_CT + 4] ? fall[`PIN_T1] : mc_tick) & (mode1 != `MODE_SPLIT);
  assign inc0h = split0 & timer_control_r[`TC_TR1] & mc_tick;

  // timer 2 mode decode
  assign baud    = timer2_control_r[`T2C_RCLK] | timer2_control_r[`T2C_SERIAL_TX_CLOCK_SELECT];
  assign timer2_updown_enable    = timer2_mode_select_r[`T2M_TIMER2_UPDOWN_ENABLE];
  assign timer2_clockout_enable    = timer2_mode_select_r[`T2M_OE];
  assign t2      = {th2_r, tl2_r};
  assign rcap    = {rcaph_r, rcapl_r};
  assign inc2    = timer2_control_r[`T2C_TR2] & (timer2_control_r[`T2C_CT2] ? fall[`PIN_T2] : mc_tick);
  assign exev    = timer2_control_r[`T2C_TIMER2_EXTERNAL_ENABLE] & ~baud & fall[`PIN_TIMER2_TRIGGER_PIN];
  assign capmode = timer2_control_r[`T2C_CPRL2] & ~baud;
  assign updown  = timer2_updown_enable & ~capmode & ~baud;

  always @* begin
    s0  = t01_step(mode0, tl0_r, th0_r);
    s1  = t01_step(mode1, tl1_r, th1_r);
    h0  = {1'b0, th0_r} + 9'h001;
    tl0_nxt = tl0_r;
    th0_nxt = th0_r;
    tl1_nxt = tl1_r;
    th1_nxt = th1_r;
    timer_control_nxt = timer_control_r;
    t1_ovf = inc1 & s1[16];
    if (inc0) begin
      tl0_nxt = s0[7:0];
      if (!split0) begin
        th0_nxt = s0[15:8];
      end
    end
    if (inc0h) begin
      th0_nxt = h0[7:0];
    end
    if (inc1) begin
      tl1_nxt = s1[7:0];
      th1_nxt = s1[15:8];
    end
    if (wr && idx == `IDX_TIMER0_COUNT_LOW) begin
      tl0_nxt = wd;
    end
    if (wr && idx == `IDX_TIMER0_COUNT_HIGH) begin
      th0_nxt = wd;
    end
    if (wr && idx == `IDX_TIMER1_COUNT_LOW) begin
      tl1_nxt = wd;
    end
    if (wr && idx == `IDX_TIMER1_COUNT_HIGH) begin
      th1_nxt = wd;
    end
    if (wr && idx == `IDX_TIMER_CONTROL) begin
      timer_control_nxt = wd;
    end
    if (timer0_ack_in) begin
      timer_control_nxt[`TC_TF0] = 1'b0;
    end
    if (timer1_ack_in) begin
      timer_control_nxt[`TC_TF1] = 1'b0;
    end
    if (ext_irq0_ack_in) begin
      timer_control_nxt[`TC_IE0] = 1'b0;
    end
    if (ext_irq1_ack_in) begin
      timer_control_nxt[`TC_IE1] = 1'b0;
    end
    // hardware sets win over clears
    if (inc0 && s0[16]) begin
      timer_control_nxt[`TC_TF0] = 1'b1;
    end
    if ((inc0h && h0[8]) || (t1_ovf && !split0)) begin
      timer_control_nxt[`TC_TF1] = 1'b1;
    end
    if (timer_control_r[`TC_IT0] && fall[`PIN_EXT_IRQ0_PIN]) begin
      timer_control_nxt[`TC_IE0] = 1'b1;
    end
    if (timer_control_r[`TC_IT1] && fall[`PIN_EXT_IRQ1_PIN]) begin
      timer_control_nxt[`TC_IE1] = 1'b1;
    end
  end

  always @* begin
    t2_nxt    = t2;
    rcap_nxt  = rcap;
    timer2_control_nxt = timer2_control_r;
    t2_ovf    = 1'b0;
    if (inc2) begin
      if (updown && !pin_cur_r[`PIN_TIMER2_TRIGGER_PIN]) begin
        if (t2 == rcap) begin
          t2_nxt = 16'hFFFF;
          t2_ovf = 1'b1;
        end else begin
          t2_nxt = t2 - 16'h0001;
        end
      end else if (t2 == 16'hFFFF) begin
        t2_ovf = 1'b1;
        t2_nxt = capmode ? 16'h0000 : rcap;
      end else begin
        t2_nxt = t2 + 16'h0001;
      end
    end
    if (exev && capmode) begin
      rcap_nxt = t2;
    end
    if (exev && !capmode && !updown) begin
      t2_nxt = rcap;
    end
    if (wr && idx == `IDX_TIMER2_COUNT_LOW) begin
      t2_nxt[7:0] = wd;
    end
    if (wr && idx == `IDX_TIMER2_COUNT_HIGH) begin
      t2_nxt[15:8] = wd;
    end
    if (wr && idx == `IDX_TIMER2_RELOAD_LOW) begin
      rcap_nxt[7:0] = wd;
    end
    if (wr && idx == `IDX_TIMER2_RELOAD_HIGH) begin
      rcap_nxt[15:8] = wd;
    end
    if (wr && idx == `IDX_TIMER2_CONTROL) begin
      timer2_control_nxt = wd;
    end
    if (t2_ovf && updown) begin
      timer2_control_nxt[`T2C_TIMER2_EXTERNAL_FLAG] = ~timer2_control_nxt[`T2C_TIMER2_EXTERNAL_FLAG];
    end
    if (t2_ovf && !baud) begin
      timer2_control_nxt[`T2C_TF2] = 1'b1;
    end
    if (exev && !updown) begin
      timer2_control_nxt[`T2C_TIMER2_EXTERNAL_FLAG] = 1'b1;
    end
  end

  // register read mux
  always @* begin
    case (idx)
      `IDX_TIMER_CONTROL:      rd_byte = timer_control_r;
      `IDX_TIMER_MODE_SELECT:  rd_byte = timer_mode_select_r;
      `IDX_TIMER0_COUNT_LOW:   rd_byte = tl0_r;
      `IDX_TIMER0_COUNT_HIGH:  rd_byte = th0_r;
      `IDX_TIMER1_COUNT_LOW:   rd_byte = tl1_r;
      `IDX_TIMER1_COUNT_HIGH:  rd_byte = th1_r;
      `IDX_CLOCK_MODE:         rd_byte = {7'h00, fast_r};
      `IDX_TIMER2_CONTROL:     rd_byte = timer2_control_r;
      `IDX_TIMER2_MODE_SELECT: rd_byte = timer2_mode_select_r;
      `IDX_TIMER2_RELOAD_LOW:  rd_byte = rcapl_r;
      `IDX_TIMER2_RELOAD_HIGH: rd_byte = rcaph_r;
      `IDX_TIMER2_COUNT_LOW:   rd_byte = tl2_r;
      `IDX_TIMER2_COUNT_HIGH:  rd_byte = th2_r;
      default:                 rd_byte = 8'h00;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
      mc_cnt_r <= 4'h0;
      timer_control_r   <= `RST_BYTE;
      timer_mode_select_r   <= `RST_BYTE;
      tl0_r    <= `RST_BYTE;
      th0_r    <= `RST_BYTE;
      tl1_r    <= `RST_BYTE;
      th1_r    <= `RST_BYTE;
      fast_r   <= 1'b0;
      timer2_control_r  <= `RST_BYTE;
      timer2_mode_select_r  <= `RST_BYTE;
      rcapl_r  <= `RST_BYTE;
      rcaph_r  <= `RST_BYTE;
      tl2_r    <= `RST_BYTE;
      th2_r    <= `RST_BYTE;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (req && avs_waitrequest_out) begin
        avs_readdata_out <= {24'h000000, rd_byte};
      end
      mc_cnt_r <= mc_tick ? 4'h0 : mc_cnt_r + 4'h1;
      timer_control_r   <= timer_control_nxt;
      tl0_r    <= tl0_nxt;
      th0_r    <= th0_nxt;
      tl1_r    <= tl1_nxt;
      th1_r    <= th1_nxt;
      timer2_control_r  <= timer2_control_nxt;
      tl2_r    <= t2_nxt[7:0];
      th2_r    <= t2_nxt[15:8];
      rcapl_r  <= rcap_nxt[7:0];
      rcaph_r  <= rcap_nxt[15:8];
      if (wr && idx == `IDX_TIMER_MODE_SELECT) begin
        timer_mode_select_r <= wd;
      end
      if (wr && idx == `IDX_TIMER2_MODE_SELECT) begin
        timer2_mode_select_r <= wd & `T2M_MASK;
      end
      if (wr && idx == `IDX_CLOCK_MODE) begin
        fast_r <= wd[0];
      end
    end
  end

  // registered outputs to the interrupt controller, serial port and pin
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      ext_irq0_req_out   <= 1'b0;
      ext_irq1_req_out   <= 1'b0;
      timer0_irq_out     <= 1'b0;
      timer1_irq_out     <= 1'b0;
      timer2_irq_out     <= 1'b0;
      serial_rx_tick_out <= 1'b0;
      serial_tx_tick_out <= 1'b0;
      clockout_port_pin_out      <= 1'b0;
      clockout_port_pin_oe_n_out <= 1'b1;
    end else begin
      ext_irq0_req_out <= timer_control_r[`TC_IT0] ? timer_control_r[`TC_IE0] : ~pin_cur_r[`PIN_EXT_IRQ0_PIN];
      ext_irq1_req_out <= timer_control_r[`TC_IT1] ? timer_control_r[`TC_IE1] : ~pin_cur_r[`PIN_EXT_IRQ1_PIN];
      timer0_irq_out   <= timer_control_r[`TC_TF0];
      timer1_irq_out   <= timer_control_r[`TC_TF1];
      timer2_irq_out   <= timer2_control_r[`T2C_TF2] | (timer2_control_r[`T2C_TIMER2_EXTERNAL_FLAG] & ~timer2_updown_enable);
      serial_rx_tick_out <= timer2_control_r[`T2C_RCLK] ? t2_ovf : t1_ovf;
      serial_tx_tick_out <= timer2_control_r[`T2C_SERIAL_TX_CLOCK_SELECT] ? t2_ovf : t1_ovf;
      if (t2_ovf && timer2_clockout_enable) begin
        clockout_port_pin_out <= ~clockout_port_pin_out;
      end
      clockout_port_pin_oe_n_out <= ~timer2_clockout_enable;
    end
  end

endmodule // triple_timer_counter_unit
`default_nettype wire

//--- tb/triple_timer_counter_unit_sva.sv
// port assertions for the triple timer/counter unit
`timescale 1ns/100ps
`default_nettype none
module triple_timer_counter_unit_sva (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        timer0_ack_in,
  input wire logic        timer0_irq_out,
  input wire logic        serial_tx_tick_out,
  input wire logic        clockout_port_pin_out,
  input wire logic        clockout_port_pin_oe_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  wire logic req = avs_read_in || avs_write_in;
  chk_wait_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait state");
  chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property (!avs_waitrequest_out |-> $past(req))
    else $error("waitrequest low without a request");
  chk_read_upper: assert property (avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
  chk_flag_clear: assert property ($fell(timer0_irq_out) |-> $past(timer0_ack_in, 2) || $past(avs_write_in, 2))
    else $error("timer 0 flag cleared without service or write");
  chk_tick_rate: assert property (serial_tx_tick_out |=> !serial_tx_tick_out [*5])
    else $error("serial tick closer than one machine cycle");
  chk_clk_owner: assert property ($changed(clockout_port_pin_out) |-> !clockout_port_pin_oe_n_out || !$past(clockout_port_pin_oe_n_out))
    else $error("clock output toggled while not enabled");
  chk_clk_rate: assert property ($changed(clockout_port_pin_out) |=> $stable(clockout_port_pin_out) [*5])
    else $error("clock output toggled faster than machine cycle");
  cover property (timer0_ack_in && timer0_irq_out);
  cover property ($changed(clockout_port_pin_out));
  cover property (serial_tx_tick_out);
endmodule // triple_timer_counter_unit_sva
bind triple_timer_counter_unit triple_timer_counter_unit_sva i_sva (
  .ref_clk_in                 (ref_clk_in),
  .srst_in                    (srst_in),
  .avs_read_in                (avs_read_in),
  .avs_write_in               (avs_write_in),
  .avs_readdata_out           (avs_readdata_out),
  .avs_waitrequest_out        (avs_waitrequest_out),
  .timer0_ack_in              (timer0_ack_in),
  .timer0_irq_out             (timer0_irq_out),
  .serial_tx_tick_out         (serial_tx_tick_out),
  .clockout_port_pin_out      (clockout_port_pin_out),
  .clockout_port_pin_oe_n_out (clockout_port_pin_oe_n_out)
);
`default_nettype wire

//--- tb/count_pin_source.sv
// external count pin source: square wave while enabled, idle high
`timescale 1ns/100ps
`default_nettype none
module count_pin_source (
  input  wire logic       clk_in,
  input  wire logic       en_in,
  input  wire logic [7:0] half_in,
  output var logic        pin_out
);
  logic [7:0] cnt_r;
  initial begin
    pin_out = 1'b1;
    cnt_r = 8'h00;
  end
  always @(posedge clk_in) begin
    cnt_r <= (!en_in || cnt_r == half_in - 8'h01) ? 8'h00 : cnt_r + 8'h01;
    if (!en_in) begin
      pin_out <= 1'b1;
    end else if (cnt_r == half_in - 8'h01) begin
      pin_out <= !pin_out;
    end
  end
endmodule // count_pin_source
`default_nettype wire

//--- tb/triple_timer_counter_unit_bench.sv
// self-checking bench for the triple timer/counter unit
`timescale 1ns/100ps
`default_nettype none
`include "triple_timer_counter_unit_map.vh"
module triple_timer_counter_unit_bench;
  localparam logic [7:0] ctl = `IDX_TIMER_CONTROL, md = `IDX_TIMER_MODE_SELECT, t1l = `IDX_TIMER1_COUNT_LOW;
  localparam logic [7:0] t0l = `IDX_TIMER0_COUNT_LOW, t0h = `IDX_TIMER0_COUNT_HIGH, t2c = `IDX_TIMER2_CONTROL;
  localparam logic [7:0] t2m = `IDX_TIMER2_MODE_SELECT, c2l = `IDX_TIMER2_RELOAD_LOW, c2h = `IDX_TIMER2_RELOAD_HIGH;
  localparam logic [7:0] t2l = `IDX_TIMER2_COUNT_LOW, t2h = `IDX_TIMER2_COUNT_HIGH, cm = `IDX_CLOCK_MODE;
  logic        clk, rst, rd, wrq, wt, pin0, pin1, trig, ack1, t0ack, src_en, cpin, ck, ck_oe_n, req1, t0i, t1i, t2i, txt;
  logic        req0, rxt;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata;
  logic [7:0]  v, w;
  logic [7:0]  regs [9] = '{ctl, md, t2c, t2m, c2l, c2h, t2l, t2h, 8'h90};
  int          n_errors = 0, n_tests = 0, n_tx = 0, tx0, n_rx = 0, rx0;
  count_pin_source i_src (.clk_in(clk), .en_in(src_en), .half_in(8'h0C), .pin_out(cpin));
  triple_timer_counter_unit i_dut (
    .ref_clk_in(clk), .srst_in(rst), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wrq),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .ext_irq0_pin_in(pin0), .ext_irq1_pin_in(pin1), .timer0_count_pin_in(cpin), .timer1_count_pin_in(1'b1),
    .timer2_count_pin_in(cpin), .timer2_trigger_pin_in(trig), .ext_irq0_ack_in(1'b0), .ext_irq1_ack_in(ack1),
    .timer0_ack_in(t0ack), .timer1_ack_in(1'b0), .ext_irq0_req_out(req0), .ext_irq1_req_out(req1),
    .timer0_irq_out(t0i), .timer1_irq_out(t1i), .timer2_irq_out(t2i), .serial_rx_tick_out(rxt),
    .serial_tx_tick_out(txt), .clockout_port_pin_out(ck), .clockout_port_pin_oe_n_out(ck_oe_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  always @(posedge clk) begin
    if (txt) n_tx <= n_tx + 1;
    if (rxt) n_rx <= n_rx + 1;
  end
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one avalon transfer: hold until waitrequest sampled low
  task automatic bus(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    addr <= {a, 2'b00};
    wdata <= {24'h000000, d};
    rd <= !wr;
    wrq <= wr;
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wrq <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d, v);
  endtask
  task automatic rm(input string nm, input logic [7:0] a, m, e);
    bus(1'b0, a, 8'h00, v);
    chk(nm, e, v & m);
  endtask
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    {rst, rd, wrq, ack1, t0ack, src_en} = 6'h20;
    {pin0, pin1, trig} = 3'h7;
    addr = 10'h000;
    wdata = 32'h00000000;
    cyc(6);
    rst <= 1'b0;
    foreach (regs[i]) rm("reset value", regs[i], 8'hFF, `RST_BYTE);
    wr(t0l, 8'h1F);
    wr(t0h, 8'hFF);
    wr(ctl, 8'h10);
    cyc(30);
    rm("tf0", ctl, 8'h20, 8'h20);
    rm("t0 high", t0h, 8'hFF, 8'h00);
    rm("t0 low top", t0l, 8'hE0, 8'h00);
    wr(ctl, 8'h00);
    bus(1'b0, t0l, 8'h00, w);
    cyc(30);
    rm("t0 stopped", t0l, 8'hFF, w);
    wr(md, 8'h01);
    wr(t0l, 8'hFF);
    wr(t0h, 8'h00);
    wr(ctl, 8'h10);
    cyc(20);
    rm("t0 carry", t0h, 8'hFF, 8'h01);
    wr(md, 8'h02);
    wr(t0h, 8'hF0);
    wr(t0l, 8'hFF);
    cyc(30);
    rm("reload kept", t0h, 8'hFF, 8'hF0);
    rm("reloaded", t0l, 8'hF0, 8'hF0);
    rm("tf0 reload", ctl, 8'h20, 8'h20);
    wr(ctl, 8'h20);
    cyc(3);
    chk("t0 irq", 8'h01, {7'h00, t0i});
    t0ack <= 1'b1;
    cyc(1);
    t0ack <= 1'b0;
    rm("tf0 serviced", ctl, 8'h20, 8'h00);
    chk("t0 irq low", 8'h00, {7'h00, t0i});
    pin0 <= 1'b0;
    wr(md, 8'h09);
    wr(t0l, 8'h00);
    wr(t0h, 8'h00);
    cyc(12);
    wr(ctl, 8'h10);
    cyc(40);
    rm("gated", t0l, 8'hFF, 8'h00);
    chk("level req0", 8'h01, {7'h00, req0});
    pin0 <= 1'b1;
    cyc(40);
    bus(1'b0, t0l, 8'h00, v);
    chk("gate open", 8'h01, {7'h00, v != 8'h00});
    chk("level req0 off", 8'h00, {7'h00, req0});
    wr(ctl, 8'h00);
    wr(md, 8'h05);
    wr(t0l, 8'h00);
    wr(ctl, 8'h10);
    cyc(40);
    rm("no edges", t0l, 8'hFF, 8'h00);
    src_en <= 1'b1;
    cyc(200);
    src_en <= 1'b0;
    bus(1'b0, t0l, 8'h00, v);
    chk("edge count", 8'h01, {7'h00, v >= 8'h01 && v <= 8'h09});
    wr(md, 8'h01);
    wr(t0l, 8'h00);
    cyc(120);
    bus(1'b0, t0l, 8'h00, v);
    chk("std rate", 8'h01, {7'h00, v >= 8'h0A && v <= 8'h0B});
    wr(cm, 8'h01);
    wr(t0l, 8'h00);
    cyc(120);
    bus(1'b0, t0l, 8'h00, v);
    chk("fast rate", 8'h01, {7'h00, v >= 8'h14 && v <= 8'h15});
    wr(cm, 8'h00);
    wr(ctl, 8'h00);
    wr(md, 8'h33);
    wr(t1l, 8'h05);
    wr(t0l, 8'h00);
    wr(t0h, 8'hFE);
    wr(ctl, 8'h40);
    cyc(40);
    rm("t1 frozen", t1l, 8'hFF, 8'h05);
    rm("split low idle", t0l, 8'hFF, 8'h00);
    rm("tf1 from split", ctl, 8'h80, 8'h80);
    chk("t1 irq", 8'h01, {7'h00, t1i});
    wr(md, 8'h00);
    wr(ctl, 8'h04);
    pin1 <= 1'b0;
    cyc(30);
    chk("edge req", 8'h01, {7'h00, req1});
    rm("ie1", ctl, 8'h08, 8'h08);
    ack1 <= 1'b1;
    cyc(1);
    ack1 <= 1'b0;
    cyc(3);
    chk("edge req served", 8'h00, {7'h00, req1});
    wr(ctl, 8'h00);
    cyc(3);
    chk("level req", 8'h01, {7'h00, req1});
    pin1 <= 1'b1;
    cyc(30);
    chk("level req off", 8'h00, {7'h00, req1});
    wr(c2l, 8'hF0);
    wr(c2h, 8'hFF);
    wr(t2l, 8'hFE);
    wr(t2h, 8'hFF);
    wr(t2m, 8'h02);
    wr(t2c, 8'h04);
    cyc(40);
    rm("t2 high", t2h, 8'hFF, 8'hFF);
    rm("t2 reload", t2l, 8'hF0, 8'hF0);
    rm("tf2", t2c, 8'h80, 8'h80);
    chk("t2 irq", 8'h01, {7'h00, t2i});
    chk("clock out enable", 8'h00, {7'h00, ck_oe_n});
    chk("clock out", 8'h01, {7'h00, ck});
    wr(t2c, 8'h34);
    tx0 = n_tx;
    rx0 = n_rx;
    cyc(300);
    chk("tx ticks", 8'h01, {7'h00, n_tx > tx0});
    chk("rx ticks", 8'h01, {7'h00, n_rx > rx0});
    rm("tf2 baud", t2c, 8'h80, 8'h00);
    wr(t2c, 8'h30);
    bus(1'b0, t2l, 8'h00, w);
    cyc(30);
    rm("t2 stopped", t2l, 8'hFF, w);
    wr(t2c, 8'h05);
    wr(t2h, 8'h12);
    wr(t2l, 8'h00);
    trig <= 1'b0;
    cyc(30);
    trig <= 1'b1;
    cyc(30);
    rm("no capture", c2h, 8'hFF, 8'hFF);
    wr(t2c, 8'h0D);
    cyc(30);
    trig <= 1'b0;
    cyc(40);
    rm("capture", c2h, 8'hFF, 8'h12);
    rm("timer2_external_flag", t2c, 8'h40, 8'h40);
    chk("t2 irq ext", 8'h01, {7'h00, t2i});
    trig <= 1'b1;
    wr(t2m, 8'h00);
    wr(c2l, 8'h34);
    wr(c2h, 8'h56);
    wr(t2c, 8'h0C);
    cyc(30);
    trig <= 1'b0;
    cyc(40);
    rm("trigger reload", t2h, 8'hFF, 8'h56);
    rm("timer2_external_flag reload", t2c, 8'h40, 8'h40);
    wr(t2c, 8'h00);
    wr(t2m, 8'h01);
    wr(c2l, 8'h10);
    wr(c2h, 8'h00);
    wr(t2l, 8'h12);
    wr(t2h, 8'h00);
    wr(t2c, 8'h04);
    cyc(60);
    rm("t2 underflow", t2h, 8'hFF, 8'hFF);
    rm("t2 down flags", t2c, 8'hC0, 8'hC0);
    chk("clock out off", 8'h01, {7'h00, ck_oe_n});
    wr(t2c, 8'h40);
    cyc(3);
    chk("no updown irq", 8'h00, {7'h00, t2i});
    wr(t2m, 8'h00);
    wr(t2l, 8'h00);
    wr(t2h, 8'h00);
    wr(t2c, 8'h06);
    cyc(40);
    rm("t2 no edges", t2l, 8'hFF, 8'h00);
    src_en <= 1'b1;
    cyc(200);
    src_en <= 1'b0;
    bus(1'b0, t2l, 8'h00, v);
    chk("t2 edge count", 8'h01, {7'h00, v >= 8'h01 && v <= 8'h09});
    end_sim;
  end
endmodule // triple_timer_counter_unit_bench
`default_nettype wire
